// ==== rtl/scfd_decoder.v ====
// Serial command frame decoder: 16-bit frames from the host, analog monitor
// select, scratch bytes and the parity enable in the miscellaneous init byte.
// Assumes SPI mode 0 (sample on rising, shift on falling) with a link clock
// well below the 20 MHz core clock; power and mode inputs share the core clock.
//
// Function
// - Frame: class in bits 15-14, address 13-9, parity/next bit 8, payload 7-0.
// - Class 00 with bit 8 set, bits 6-0 zero reads status and register bits.
// - Class 00 read with bit 7 set returns status and identity/I-O state byte.
// - Class 01 writes payload to register; answer is status plus extended status.
// - Class 11 returns status plus flags of the addressed register.
// - Flag read: bit 7 low gives lower group, high gives upper group.
// - Parity covers write frames only, over bits 15-9 and 7-0.
// - Parity is checked only when misc init bit 6 is set.
// - Monitor: source bits 7-5, load resistor bit 4, gain/atten bit 3, rest zero.
// - Source codes: off, current, reference, temperature, io0, io1, supply, sense.
// - Monitor clears on power-on reset, regulator off, or non-normal mode.
// - Load resistor bit 1 connects internal resistor; 0 leaves it open.
// - Gain/atten bit acts only for io0 or io1 source: 0 gain, 1 attenuation.
// - Address 0 monitor, 1 to 4 scratch bytes, 8 misc init.
// - Regulator off: monitor access ignored and register reset.
`timescale 1ns/10ps
`include "scfd_regs.vh"

module scfd_decoder (
  input wire clock,
  input wire rst,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output wire spi_miso,
  output wire spi_miso_oe,
  input wire [7:0] status_fixed,
  input wire [7:0] status_extended,
  input wire [7:0] device_info,
  input wire [7:0] flags_lower,
  input wire [7:0] flags_upper,
  output wire [4:0] flag_addr,
  input wire can_reg_on,
  input wire mode_normal,
  output reg [2:0] monitor_source_sel,
  output reg internal_load_resistor_en,
  output reg monitor_io_gain_en,
  output reg monitor_io_atten_en,
  output reg [7:0] monitor_select_value,
  output reg parity_en,
  output reg frame_done,
  output reg frame_rejected
);

  // One two-flop synchroniser per pin, then one more stage on link clock and frame select for edge detection.
  // Bit order: 0 link clock, 1 frame select, 2 host data
  localparam [2:0] PIN_IDLE = 3'b010;
  wire [2:0] pin_raw = {spi_mosi, spi_cs_n, spi_sclk};
  wire [2:0] pin_sync;
  genvar g;

  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_pin_sync
      reg [1:0] sync_reg;
      // Reset to the idle level of each pin so no false edge follows reset
      always @(posedge clock) begin
        if (rst) begin
          sync_reg <= {2{PIN_IDLE[g]}};
        end else begin
          sync_reg <= {sync_reg[0], pin_raw[g]};
        end
      end
      assign pin_sync[g] = sync_reg[1];
    end
  endgenerate

  wire sclk_sync = pin_sync[0];
  wire cs_sync = pin_sync[1];
  wire mosi_sync = pin_sync[2];
  reg sclk_last_reg;
  reg cs_last_reg;

  // Previous synchronised levels; only the second flop of the link clock and frame select pins feeds these
  always @(posedge clock) begin
    if (rst) begin
      sclk_last_reg <= 1'b0;
      cs_last_reg <= 1'b1;
    end else begin
      sclk_last_reg <= sclk_sync;
      cs_last_reg <= cs_sync;
    end
  end

  // Edges are seen about three core clocks after the pin moves, so the link
  // clock half period must stay at four core clocks or more
  wire sclk_rise = sclk_sync & ~sclk_last_reg;
  wire sclk_fall = ~sclk_sync & sclk_last_reg;
  wire cs_active = ~cs_sync;
  wire frame_start = ~cs_sync & cs_last_reg;
  wire frame_end = cs_sync & ~cs_last_reg;

  reg [15:0] rx_reg;
  reg [15:0] tx_reg;
  reg [15:0] resp_reg;
  reg [4:0] bit_cnt_reg;
  reg miso_oe_reg;

  reg [7:0] monitor_reg;
  reg [7:0] misc_init_reg;
  reg [7:0] scratch_mem [0:3];

  assign spi_miso = tx_reg[15];
  assign spi_miso_oe = miso_oe_reg;
  assign flag_addr = rx_reg[`SCFD_ADDR_HI:`SCFD_ADDR_LO];

  // Frame field decode
  wire [1:0] cmd_class = rx_reg[`SCFD_CLASS_HI:`SCFD_CLASS_LO];
  wire [4:0] cmd_addr = rx_reg[`SCFD_ADDR_HI:`SCFD_ADDR_LO];
  wire cmd_next = rx_reg[`SCFD_PARITY_BIT];
  wire cmd_sub = rx_reg[`SCFD_SUB_BIT];
  wire [7:0] cmd_data = rx_reg[7:0];
  wire full_frame = (bit_cnt_reg == `SCFD_FRAME_BITS);
  wire is_monitor = (cmd_addr == `SCFD_ADDR_MONITOR);
  wire is_misc = (cmd_addr == `SCFD_ADDR_MISC_INIT);
  wire is_scratch = (cmd_addr >= `SCFD_ADDR_SCRATCH_A) &&
                    (cmd_addr <= `SCFD_ADDR_SCRATCH_D);
  wire [4:0] scratch_off = cmd_addr - `SCFD_ADDR_SCRATCH_A;
  wire [1:0] scratch_idx = scratch_off[1:0];
  wire [3:0] scratch_hit = 4'h1 << scratch_idx;

  // Command class decode
  wire cls_read = (cmd_class == `SCFD_CLASS_READ);
  wire cls_write = (cmd_class == `SCFD_CLASS_WRITE);
  wire cls_rsvd = (cmd_class == `SCFD_CLASS_RSVD);
  wire cls_flags = (cmd_class == `SCFD_CLASS_FLAGS);

  // Odd total weight over all sixteen bits means bit 8 completes the count
  // over bits 15-9 and 7-0 to odd, as the host must send it
  wire parity_odd = ^rx_reg;
  wire parity_ok = ~misc_init_reg[`SCFD_MISC_PARITY_BIT] | parity_odd;
  wire read_ok = cmd_next && (cmd_data[6:0] == 7'h00);
  wire monitor_hold = ~can_reg_on | ~mode_normal;

  // A write executes only at the end of a complete frame; bits past the
  // sixteenth are not counted, so an over-long frame still executes
  wire do_write = frame_end && full_frame && cls_write && parity_ok;
  wire bad_frame = frame_end && (~full_frame || cls_rsvd ||
                   (cls_read && ~read_ok) ||
                   (cls_write && ~parity_ok));
  wire flag_frame = cls_flags && full_frame;

  // Control bits of the addressed register for a read-back.
  // Unmapped addresses read back as zero rather than holding the bus value
  reg [7:0] reg_readback;
  always @* begin
    reg_readback = 8'h00;
    if (is_monitor) begin
      reg_readback = can_reg_on ? monitor_reg : 8'h00;
    end else if (is_scratch) begin
      reg_readback = scratch_mem[scratch_idx];
    end else if (is_misc) begin
      reg_readback = misc_init_reg;
    end
  end

  // Answer to this frame; shifted out during the next frame
  reg [15:0] resp_next;
  always @* begin
    resp_next = resp_reg;
    case (cmd_class)
      `SCFD_CLASS_READ: begin
        if (read_ok) begin
          if (cmd_sub) begin
            resp_next = {status_fixed, device_info};
          end else begin
            resp_next = {status_fixed, reg_readback};
          end
        end
      end
      `SCFD_CLASS_WRITE: begin
        resp_next = {status_fixed, status_extended};
      end
      `SCFD_CLASS_FLAGS: begin
        if (cmd_sub) begin
          resp_next = {status_fixed, flags_upper};
        end else begin
          resp_next = {status_fixed, flags_lower};
        end
      end
      default: begin
        resp_next = resp_reg;
      end
    endcase
  end

  // Shift engine: a short frame is counted but never executed.
  // The answer is loaded at the start of the next frame, so the host sees the
  // result of the previous command; a short, reserved-class or bad read frame
  // leaves the answer before it. This trades one frame of
  // latency for no timing path from the last bit to the first answer bit
  always @(posedge clock) begin
    if (rst) begin
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      resp_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
      miso_oe_reg <= 1'b0;
      frame_done <= 1'b0;
      frame_rejected <= 1'b0;
    end else begin
      frame_done <= frame_end & full_frame;
      frame_rejected <= bad_frame;
      if (frame_start) begin
        tx_reg <= resp_reg;
        bit_cnt_reg <= 5'h00;
        miso_oe_reg <= 1'b1;
      end else if (cs_active) begin
        if (sclk_rise && !full_frame) begin
          rx_reg <= {rx_reg[14:0], mosi_sync};
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
        if (sclk_fall) begin
          tx_reg <= {tx_reg[14:0], 1'b0};
        end
      end
      if (frame_end) begin
        miso_oe_reg <= 1'b0;
        if (full_frame) begin
          resp_reg <= resp_next;
        end
      end
    end
  end

  // Register file. The monitor clear condition wins over a write in the
  // same cycle, so a write while the regulator is off is simply lost
  always @(posedge clock) begin
    if (rst) begin
      monitor_reg <= `SCFD_MON_RESET;
      misc_init_reg <= `SCFD_MISC_RESET;
    end else begin
      if (monitor_hold) begin
        monitor_reg <= `SCFD_MON_RESET;
      end else if (do_write && is_monitor) begin
        monitor_reg <= cmd_data & `SCFD_MON_WMASK;
      end
      if (do_write && is_misc) begin
        misc_init_reg <= cmd_data;
      end
    end
  end

  // Scratch bytes, one write port per entry; flag reads never touch them
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_scratch
      always @(posedge clock) begin
        if (rst) begin
          scratch_mem[g] <= `SCFD_SCRATCH_RESET;
        end else if (do_write && is_scratch && scratch_hit[g] && !flag_frame) begin
          scratch_mem[g] <= cmd_data;
        end
      end
    end
  endgenerate

  // Decoded monitor controls, registered so they change together
  wire [2:0] src_now = monitor_reg[`SCFD_MON_SRC_HI:`SCFD_MON_SRC_LO];
  wire src_is_io = (src_now == `SCFD_SRC_IO0) || (src_now == `SCFD_SRC_IO1);

  always @(posedge clock) begin
    if (rst) begin
      monitor_source_sel <= `SCFD_SRC_OFF;
      internal_load_resistor_en <= 1'b0;
      monitor_io_gain_en <= 1'b0;
      monitor_io_atten_en <= 1'b0;
      monitor_select_value <= `SCFD_MON_RESET;
      parity_en <= 1'b0;
    end else begin
      monitor_source_sel <= src_now;
      internal_load_resistor_en <= monitor_reg[`SCFD_MON_LOAD_BIT];
      monitor_io_gain_en <= src_is_io & ~monitor_reg[`SCFD_MON_ATT_BIT];
      monitor_io_atten_en <= src_is_io & monitor_reg[`SCFD_MON_ATT_BIT];
      monitor_select_value <= monitor_reg;
      parity_en <= misc_init_reg[`SCFD_MISC_PARITY_BIT];
    end
  end

endmodule

// ==== rtl/scfd_regs.vh ====
// Constants for the serial command frame decoder: frame fields, register
// addresses, field positions and reset values. Definitions only.
`ifndef SCFD_REGS_VH
`define SCFD_REGS_VH

`define SCFD_FRAME_BITS 5'h10
`define SCFD_CLASS_HI 15
`define SCFD_CLASS_LO 14
`define SCFD_ADDR_HI 13
`define SCFD_ADDR_LO 9
`define SCFD_PARITY_BIT 8
`define SCFD_SUB_BIT 7

`define SCFD_CLASS_READ 2'h0
`define SCFD_CLASS_WRITE 2'h1
`define SCFD_CLASS_RSVD 2'h2
`define SCFD_CLASS_FLAGS 2'h3

`define SCFD_ADDR_MONITOR 5'h00
`define SCFD_ADDR_SCRATCH_A 5'h01
`define SCFD_ADDR_SCRATCH_D 5'h04
`define SCFD_ADDR_MISC_INIT 5'h08

`define SCFD_MON_SRC_HI 7
`define SCFD_MON_SRC_LO 5
`define SCFD_MON_LOAD_BIT 4
`define SCFD_MON_ATT_BIT 3
`define SCFD_MON_WMASK 8'hF8
`define SCFD_MON_RESET 8'h00
`define SCFD_SCRATCH_RESET 8'h00
`define SCFD_MISC_RESET 8'h00
`define SCFD_MISC_PARITY_BIT 6

`define SCFD_SRC_OFF 3'h0
`define SCFD_SRC_REG_CURRENT 3'h1
`define SCFD_SRC_REFERENCE 3'h2
`define SCFD_SRC_TEMP 3'h3
`define SCFD_SRC_IO0 3'h4
`define SCFD_SRC_IO1 3'h5
`define SCFD_SRC_SUPPLY 3'h6
`define SCFD_SRC_SENSE 3'h7

`endif

// ==== testbench/scfd_host.sv ====
// Host model: mode 0 master, 16-bit frames MSB first, 400 ns link clock.
// Assumes a 50 ns core clock; each answer belongs to the frame before.
`timescale 1ns/10ps
module scfd_host (
  input wire clock,
  input wire spi_miso,
  output reg spi_sclk = 1'b0,
  output reg spi_cs_n = 1'b1,
  output reg spi_mosi = 1'b1,
  output reg [15:0] rx_word = 16'h0000,
  output reg rx_valid = 1'b0
);
  task xfer(input [15:0] f);
    integer i;
    begin
      @(posedge clock) #1 spi_cs_n = 1'b0;
      #100;
      for (i = 15; i >= 0; i = i - 1) begin
        spi_mosi = f[i];
        #200 spi_sclk = 1'b1;
        rx_word[i] = spi_miso;
        #200 spi_sclk = 1'b0;
      end
      #200 spi_cs_n = 1'b1;
      // A released line shows the inverse, never the stale bit
      spi_mosi = ~spi_mosi;
      rx_valid = 1'b1;
      #50 rx_valid = 1'b0;
      #300;
    end
  endtask
endmodule

// ==== testbench/scfd_monitor.sv ====
// Checker for the frame decoder ports, bound to the decoder.
// Assumes all ports are sampled on the core clock, rst synchronous.
`timescale 1ns/10ps
module scfd_monitor (
  input wire clock,
  input wire rst,
  input wire spi_cs_n,
  input wire spi_miso_oe,
  input wire can_reg_on,
  input wire mode_normal,
  input wire [2:0] monitor_source_sel,
  input wire internal_load_resistor_en,
  input wire monitor_io_gain_en,
  input wire monitor_io_atten_en,
  input wire [7:0] monitor_select_value,
  input wire frame_done,
  input wire frame_rejected
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire io_src = monitor_select_value[7:6] == 2'h2;
  wire att = monitor_select_value[3];
  oe_idle_a: assert property (spi_cs_n [*5] |-> !spi_miso_oe) else $error("oe outside frame");
  oe_frame_a: assert property ($fell(spi_cs_n) |-> ##[1:6] spi_miso_oe) else $error("oe late");
  done_pulse_a: assert property (frame_done |=> !frame_done) else $error("done not a pulse");
  rej_pulse_a: assert property (frame_rejected |=> !frame_rejected) else $error("reject not a pulse");
  mon_clear_a: assert property (!(can_reg_on && mode_normal) |-> ##2 monitor_select_value == 8'h00)
    else $error("monitor not cleared");
  mon_mask_a: assert property (monitor_select_value[2:0] == 3'h0) else $error("low bits set");
  src_map_a: assert property ($stable(monitor_select_value) |-> monitor_source_sel == monitor_select_value[7:5]
    && internal_load_resistor_en == monitor_select_value[4]) else $error("source map");
  io_map_a: assert property ($stable(monitor_select_value) |-> monitor_io_gain_en == (io_src && !att)
    && monitor_io_atten_en == (io_src && att)) else $error("gain map");
  cover property (frame_rejected);
  cover property (monitor_io_atten_en);
  cover property (frame_done && !can_reg_on);
endmodule
bind scfd_decoder scfd_monitor mon_chk (.clock, .rst, .spi_cs_n, .spi_miso_oe, .can_reg_on, .mode_normal,
  .monitor_source_sel, .internal_load_resistor_en, .monitor_io_gain_en, .monitor_io_atten_en,
  .monitor_select_value, .frame_done, .frame_rejected);

// ==== testbench/spi_command_frame_decoder_tb_top.sv ====
// Bench for the frame decoder: host model frames, queued answers.
// Assumes a 50 ns core clock; answers lag one frame.
`timescale 1ns/10ps
module spi_command_frame_decoder_tb_top;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg can_reg_on = 1'b1;
  reg mode_normal = 1'b1;
  reg [7:0] status_fixed = 8'h00, status_extended = 8'h00, device_info = 8'h00, flags_lower = 8'h00;
  reg [7:0] flags_upper = 8'h00;
  reg [31:0] seed = 32'h0000_0058;
  reg [15:0] exp_q[$];
  reg [15:0] last_ans;
  reg [15:0] w;
  reg a;
  reg io;
  integer fail_count = 0, checks = 0, rej_n = 0, i;
  wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, frame_done, frame_rejected, parity_en;
  wire load, gain, att, rx_valid;
  wire [2:0] src;
  wire [4:0] flag_addr;
  wire [7:0] mon;
  wire [15:0] rx_word;
  always #25 clock = ~clock;
  scfd_decoder uut (.clock, .rst, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe, .status_fixed,
    .status_extended, .device_info, .flags_lower, .flags_upper, .flag_addr, .can_reg_on, .mode_normal,
    .monitor_source_sel(src), .internal_load_resistor_en(load), .monitor_io_gain_en(gain),
    .monitor_io_atten_en(att), .monitor_select_value(mon), .parity_en, .frame_done, .frame_rejected);
  scfd_host host (.clock, .spi_miso, .spi_sclk, .spi_cs_n, .spi_mosi, .rx_word, .rx_valid);
  function [15:0] mk(input [1:0] c, input [4:0] ad, input b, input [7:0] p);
    mk = {c, ad, b, p};
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cmd(input [15:0] f, input [15:0] ans);
    begin
      exp_q.push_back(ans);
      last_ans = ans;
      host.xfer(f);
    end
  endtask
  task rnd;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      {status_fixed, status_extended, device_info, flags_lower} = seed;
      flags_upper = seed[7:0] ^ seed[31:24];
    end
  endtask
  task give_verdict;
    begin
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  always @(posedge clock) if (frame_rejected === 1'b1) rej_n <= rej_n + 1;
  always @(posedge rx_valid) chk(rx_word, exp_q.pop_front());
  initial begin
    #400000;
    fail_count = fail_count + 1;
    give_verdict;
  end
  initial begin
    exp_q.push_back(16'h0000);
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    rnd;
    cmd(mk(2'h1, 5'h00, 1'b0, 8'hFF), {status_fixed, status_extended});
    chk(mon, 16'h00F8);
    cmd(mk(2'h0, 5'h00, 1'b1, 8'h00), {status_fixed, 8'hF8});
    for (i = 0; i < 16; i = i + 1) begin
      rnd;
      a = i[3] ^ i[0];
      io = i[2:1] == 2'h2;
      cmd(mk(2'h1, 5'h00, 1'b0, {i[2:0], i[3], a, 3'h0}), {status_fixed, status_extended});
      chk({src, load, gain, att}, {i[2:0], i[3], io && !a, io && a});
    end
    cmd(mk(2'h0, 5'h00, 1'b1, 8'h80), {status_fixed, device_info});
    for (i = 0; i < 2; i = i + 1) begin
      rnd;
      cmd(mk(2'h3, 5'h11, 1'b1, {i[0], 7'h00}), {status_fixed, i[0] ? flags_upper : flags_lower});
      chk(flag_addr, 16'h0011);
    end
    w = mk(2'h1, 5'h03, 1'b0, flags_upper);
    cmd(w, {status_fixed, status_extended});
    cmd(mk(2'h2, 5'h03, 1'b0, ~w[7:0]), last_ans);
    cmd(mk(2'h0, 5'h00, 1'b0, 8'h00), last_ans);
    cmd(mk(2'h0, 5'h03, 1'b1, 8'h00), {status_fixed, w[7:0]});
    chk(rej_n, 16'h0002);
    cmd(mk(2'h1, 5'h08, 1'b0, 8'h40), {status_fixed, status_extended});
    chk(parity_en, 16'h0001);
    w = mk(2'h1, 5'h00, 1'b0, 8'h60);
    w[8] = ^{w[15:9], w[7:0]};
    cmd(w, last_ans);
    chk(mon, 16'h00F0);
    w[8] = ~^{w[15:9], w[7:0]};
    cmd(w, {status_fixed, status_extended});
    chk(mon, 16'h0060);
    chk(rej_n, 16'h0003);
    mode_normal = 1'b0;
    repeat (3) @(posedge clock);
    #1 chk(mon, 16'h0000);
    mode_normal = 1'b1;
    can_reg_on = 1'b0;
    cmd(mk(2'h1, 5'h00, 1'b0, 8'hA0), {status_fixed, status_extended});
    chk(mon, 16'h0000);
    chk(rej_n, 16'h0003);
    cmd(mk(2'h0, 5'h00, 1'b1, 8'h00), {status_fixed, 8'h00});
    can_reg_on = 1'b1;
    cmd(mk(2'h0, 5'h01, 1'b1, 8'h00), {status_fixed, 8'h00});
    cmd(mk(2'h2, 5'h00, 1'b0, 8'h00), last_ans);
    chk(rej_n, 16'h0004);
    give_verdict;
  end
endmodule
